// ---- i2cm_defines.svh ----
// register map, field positions and counts for the i2c master timing block
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

`define I2CM_A_RELOAD   8'h00
`define I2CM_A_TXBUF    8'h04
`define I2CM_A_CTRL     8'h08
`define I2CM_A_STAT     8'h0C
`define I2CM_A_CFG      8'h10

`define I2CM_C_START    0
`define I2CM_C_RSTART   1
`define I2CM_C_ACKST    6

`define I2CM_S_BF       0
`define I2CM_S_WRITE_COLLISION_FLAG     1
`define I2CM_S_SSEEN    2
`define I2CM_S_EVT      3
`define I2CM_S_BCOL     4
`define I2CM_S_BUSY     5

`define I2CM_G_FULLW    0
`define I2CM_FULLW_RST  1'b1

`define I2CM_RL_LOW_MSB 6
`define I2CM_LAST_DATA  4'h7
`define I2CM_ACK_BIT    4'h8
`define I2CM_BIT_ONE    4'h1
`define I2CM_CNT_ONE    8'h01
`define I2CM_CNT_ZERO   8'h00

`endif

// ---- i2cm_pkg.sv ----
// types for the i2c master timing block
package i2cm_pkg;

	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_WAIT  = 11'h002,
		ST_HOLD  = 11'h004,
		RS_LOW   = 11'h008,
		RS_REL   = 11'h010,
		RS_RISE  = 11'h020,
		RS_HIGH  = 11'h040,
		RS_SDA   = 11'h080,
		TX_LOW   = 11'h100,
		TX_RISE  = 11'h200,
		TX_HIGH  = 11'h400
	} i2cm_state_e;

	typedef struct packed {
		i2cm_state_e st;
		logic [7:0]  cnt;
		logic        pre;
		logic [7:0]  reload;
		logic [7:0]  txbuf;
		logic [7:0]  shf;
		logic [3:0]  bitn;
		logic        scl_oe;
		logic        sda_oe;
		logic        lo;
		logic        sreq;
		logic        rreq;
		logic        fullw;
		logic        bf;
		logic        write_collision_flag;
		logic        sseen;
		logic        evt;
		logic        bcol;
		logic        ackst;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        scl_m;
		logic        scl_s;
		logic        sda_m;
		logic        sda_s;
	} i2cm_regs_s;

endpackage : i2cm_pkg

// ---- i2cm_timing.sv ----
// i2c master start, repeated start and byte transmit timing engine
`timescale 1ns/10ps
`include "i2cm_defines.svh"

// Behaviour
// RQ1: counter reloads from divider; buffer write starts
// RQ2: counter stops when operation completes
// RQ3: scl rate is clock over four(reload+1)
// RQ4: released scl waits high, reloads low seven
// RQ5: high phase lasts at least one rollover
// RQ6: start waits rollover high, drives sda low
// RQ7: start hold uses full reload, then stops
// RQ8: lines low at start means collision, idle
// RQ9: buffer write during start is discarded, flagged
// RQ10: control low bits locked until start done
// RQ11: repeated start pulls scl, releases sda
// RQ12: both high one rollover, sda low one
// RQ13: start seen set; event after timeout
// RQ14: repeated start ignored while busy
// RQ15: repeated start collision on sda or scl
// RQ16: buffer and control writes blocked meanwhile
// RQ17: software then loads address or data
// RQ18: buffer write sets full, starts shifting
// RQ19: bit after scl falls; low, high rollover
// RQ20: eighth fall clears full, releases sda
// RQ21: ninth fall samples acknowledge into flag
// RQ22: after ninth, event set, scl held low
// RQ23: collision flags, clears full, releases lines
// RQ24: start hold reload width is configurable
module i2cm_timing
	import i2cm_pkg::*;
(
	input  wire logic        sys_clk_in,    // core clock
	input  wire logic        rst_n_in,      // async reset
	input  wire logic        psel_in,       // apb select
	input  wire logic        penable_in,    // apb enable
	input  wire logic        pwrite_in,     // apb write
	input  wire logic [7:0]  paddr_in,      // apb address
	input  wire logic [31:0] pwdata_in,     // apb write data
	output logic      [31:0] prdata_out,    // apb read data
	output logic             pready_out,    // apb ready
	output logic             pslverr_out,   // apb error
	input  wire logic        scl_in,        // scl pin level
	output logic             scl_out_out,   // scl drive level
	output logic             scl_oe_out,    // scl pulled low
	input  wire logic        sda_in,        // sda pin level
	output logic             sda_out_out,   // sda drive level
	output logic             sda_oe_out     // sda pulled low
);
	import i2cm_pkg::*;

	i2cm_regs_s  r;
	i2cm_regs_s  n;
	logic        tick;
	logic        to;
	logic        run;
	logic        busy;
	logic        setup;
	logic        wr;
	logic        ld;
	logic [7:0]  ldv;
	logic [7:0]  low7;
	logic        col;
	logic        hit;
	logic [31:0] rd;

	assign tick  = r.pre;
	assign to    = tick && (r.cnt == `I2CM_CNT_ZERO);
	assign busy  = (r.st != ST_IDLE) || r.sreq || r.rreq;
	assign setup = psel_in && !penable_in;
	assign wr    = psel_in && penable_in && r.pready && pwrite_in;
	assign low7  = {1'b0, r.reload[`I2CM_RL_LOW_MSB:0]};
	assign run   = (r.st != ST_IDLE) && (r.st != RS_LOW)
		&& (r.st != RS_RISE) && (r.st != TX_RISE);

	always_comb
	begin
		n   = r;
		ld  = 1'b0;
		ldv = low7;
		col = 1'b0;
		hit = 1'b1;
		rd  = '0;
		n.scl_m = scl_in;
		n.scl_s = r.scl_m;
		n.sda_m = sda_in;
		n.sda_s = r.sda_m;
		// divide by two, then count down one rollover
		if (run) // [RQ3]
		begin
			n.pre = ~r.pre;
			if (tick && (r.cnt != `I2CM_CNT_ZERO))
			begin
				n.cnt = r.cnt - `I2CM_CNT_ONE;
			end
		end
		// apb read decode in the setup cycle
		if (paddr_in == `I2CM_A_RELOAD)
		begin
			rd[7:0] = r.reload;
		end
		else if (paddr_in == `I2CM_A_TXBUF)
		begin
			rd[7:0] = r.txbuf;
		end
		else if (paddr_in == `I2CM_A_CTRL)
		begin
			rd[`I2CM_C_START]  = r.sreq;
			rd[`I2CM_C_RSTART] = r.rreq;
			rd[`I2CM_C_ACKST]  = r.ackst;
		end
		else if (paddr_in == `I2CM_A_STAT)
		begin
			rd[`I2CM_S_BF]    = r.bf;
			rd[`I2CM_S_WRITE_COLLISION_FLAG]  = r.write_collision_flag;
			rd[`I2CM_S_SSEEN] = r.sseen;
			rd[`I2CM_S_EVT]   = r.evt;
			rd[`I2CM_S_BCOL]  = r.bcol;
			rd[`I2CM_S_BUSY]  = busy;
		end
		else if (paddr_in == `I2CM_A_CFG)
		begin
			rd[`I2CM_G_FULLW] = r.fullw;
		end
		else
		begin
			hit = 1'b0;
		end
		n.pready  = setup;
		n.pslverr = setup && !hit;
		if (setup)
		begin
			n.prdata = rd;
		end
		// apb writes; flag clears come first so sets win
		if (wr)
		begin
			if (paddr_in == `I2CM_A_RELOAD)
			begin
				n.reload = pwdata_in[7:0]; // [RQ1]
			end
			else if (paddr_in == `I2CM_A_TXBUF)
			begin
				if (busy) // [RQ9] [RQ16]
				begin
					n.write_collision_flag = 1'b1;
				end
				else // [RQ18] [RQ1]
				begin
					n.txbuf  = pwdata_in[7:0];
					n.shf    = pwdata_in[7:0];
					n.bf     = 1'b1;
					n.bitn   = '0;
					n.scl_oe = 1'b1;
					n.st     = TX_LOW;
					ld       = 1'b1;
				end
			end
			else if (paddr_in == `I2CM_A_CTRL)
			begin
				if (!busy) // [RQ10] [RQ14] [RQ16]
				begin
					n.sreq = pwdata_in[`I2CM_C_START];
					n.rreq = pwdata_in[`I2CM_C_RSTART]
						&& !pwdata_in[`I2CM_C_START];
				end
			end
			else if (paddr_in == `I2CM_A_STAT)
			begin
				if (pwdata_in[`I2CM_S_WRITE_COLLISION_FLAG])
				begin
					n.write_collision_flag = 1'b0;
				end
				if (pwdata_in[`I2CM_S_SSEEN])
				begin
					n.sseen = 1'b0;
				end
				if (pwdata_in[`I2CM_S_EVT])
				begin
					n.evt = 1'b0;
				end
				if (pwdata_in[`I2CM_S_BCOL])
				begin
					n.bcol = 1'b0;
				end
			end
			else if (paddr_in == `I2CM_A_CFG)
			begin
				n.fullw = pwdata_in[`I2CM_G_FULLW]; // [RQ24]
			end
		end
		// sequencer
		case (r.st)
			ST_IDLE:
			begin
				if (r.sreq)
				begin
					if (r.sda_s && r.scl_s) // [RQ6]
					begin
						ld   = 1'b1;
						n.st = ST_WAIT;
					end
					else
					begin
						col = 1'b1; // [RQ8]
					end
				end
				else if (r.rreq)
				begin
					n.scl_oe = 1'b1; // [RQ11]
					n.st     = RS_LOW;
				end
			end
			ST_WAIT:
			begin
				if (!r.scl_s || !r.sda_s)
				begin
					col = 1'b1; // [RQ8]
				end
				else if (to)
				begin
					n.sda_oe = 1'b1; // [RQ6]
					n.sseen  = 1'b1; // [RQ13]
					ld       = 1'b1;
					if (r.fullw)
					begin
						ldv = r.reload; // [RQ7] [RQ24]
					end
					n.st = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (to) // [RQ7] [RQ2]
				begin
					n.sreq = 1'b0;
					n.evt  = 1'b1;
					n.st   = ST_IDLE;
				end
			end
			RS_LOW:
			begin
				if (!r.scl_s) // [RQ11]
				begin
					ld       = 1'b1;
					n.sda_oe = 1'b0;
					n.st     = RS_REL;
				end
			end
			RS_REL:
			begin
				if (to)
				begin
					if (r.sda_s) // [RQ11]
					begin
						n.scl_oe = 1'b0;
						n.st     = RS_RISE;
					end
					else
					begin
						col = 1'b1; // [RQ15]
					end
				end
			end
			RS_RISE:
			begin
				if (r.scl_s)
				begin
					if (!r.sda_s)
					begin
						col = 1'b1; // [RQ15]
					end
					else
					begin
						ld   = 1'b1; // [RQ12] [RQ4]
						n.st = RS_HIGH;
					end
				end
			end
			RS_HIGH:
			begin
				if (!r.scl_s || !r.sda_s)
				begin
					col = 1'b1; // [RQ15]
				end
				else if (to)
				begin
					n.sda_oe = 1'b1; // [RQ12]
					n.sseen  = 1'b1; // [RQ13]
					ld       = 1'b1;
					n.st     = RS_SDA;
				end
			end
			RS_SDA:
			begin
				if (!r.scl_s)
				begin
					col = 1'b1; // [RQ15]
				end
				else if (to) // [RQ12] [RQ13]
				begin
					n.rreq = 1'b0;
					n.evt  = 1'b1;
					n.st   = ST_IDLE;
				end
			end
			TX_LOW:
			begin
				if (!r.scl_s) // [RQ19] [RQ20]
				begin
					n.sda_oe = (r.bitn != `I2CM_ACK_BIT)
						&& !r.shf[7];
				end
				// release only once the bit has been placed
				if (to && !r.scl_s) // [RQ19]
				begin
					n.scl_oe = 1'b0;
					n.st     = TX_RISE;
				end
			end
			TX_RISE:
			begin
				if (r.scl_s) // [RQ4] [RQ5]
				begin
					ld   = 1'b1;
					n.st = TX_HIGH;
				end
			end
			TX_HIGH:
			begin
				if ((r.bitn != `I2CM_ACK_BIT) && !r.sda_oe
					&& !r.sda_s)
				begin
					col = 1'b1; // [RQ23]
				end
				else if (to)
				begin
					n.scl_oe = 1'b1; // [RQ19]
					n.bitn   = r.bitn + `I2CM_BIT_ONE;
					n.shf    = {r.shf[6:0], 1'b0};
					if (r.bitn == `I2CM_ACK_BIT)
					begin
						n.ackst = r.sda_s; // [RQ21]
						n.evt   = 1'b1;    // [RQ22]
						n.bitn  = '0;
						n.st    = ST_IDLE; // [RQ2]
					end
					else
					begin
						if (r.bitn == `I2CM_LAST_DATA)
						begin
							n.bf = 1'b0; // [RQ20]
						end
						ld   = 1'b1;
						n.st = TX_LOW;
					end
				end
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase
		if (ld)
		begin
			n.cnt = ldv;
			n.pre = 1'b0;
		end
		// abort: flag, drop requests, release both lines
		if (col) // [RQ23] [RQ8] [RQ15]
		begin
			n.bcol   = 1'b1;
			n.sreq   = 1'b0;
			n.rreq   = 1'b0;
			n.bf     = 1'b0;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.bitn   = '0;
			n.st     = ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r       <= '0;
			r.st    <= ST_IDLE;
			r.fullw <= `I2CM_FULLW_RST;
		end
		else
		begin
			r <= n;
		end
	end

	assign prdata_out  = r.prdata;
	assign pready_out  = r.pready;
	assign pslverr_out = r.pslverr;
	assign scl_out_out = r.lo;
	assign scl_oe_out  = r.scl_oe;
	assign sda_out_out = r.lo;
	assign sda_oe_out  = r.sda_oe;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_rs_high_done;
		(r.st == RS_HIGH) && to && r.scl_s && r.sda_s;
	endsequence

	sequence s_sda_low_rollover;
		(r.st == RS_SDA) && r.sda_oe && !r.scl_oe;
	endsequence

	chk_idle_counter_stops: assert property ( // [RQ2]
		(r.st == ST_IDLE) ##1 (r.st == ST_IDLE) |-> $stable(r.cnt))
		else $error("counter moved while idle");

	chk_high_reload_low: assert property ( // [RQ4]
		$rose(r.st == TX_HIGH) |-> (r.cnt == low7) && !r.pre)
		else $error("high phase reload wrong");

	chk_start_drives_sda: assert property ( // [RQ6]
		$rose(r.st == ST_HOLD) |-> r.sda_oe && r.sseen
			&& !r.scl_oe)
		else $error("start did not drive sda low");

	chk_start_completes: assert property ( // [RQ7]
		(r.st == ST_HOLD) && to |=> (r.st == ST_IDLE)
			&& !r.sreq && r.sda_oe && r.evt)
		else $error("start did not complete");

	chk_start_collision: assert property ( // [RQ8]
		(r.st == ST_WAIT) && (!r.scl_s || !r.sda_s)
			|=> r.bcol && !r.sreq
			&& (r.st == ST_IDLE) && !r.scl_oe && !r.sda_oe)
		else $error("start collision not handled");

	chk_buffer_write_col: assert property ( // [RQ9]
		wr && (paddr_in == `I2CM_A_TXBUF) && busy
			|=> r.write_collision_flag && $stable(r.txbuf))
		else $error("buffer write not discarded");

	chk_ctrl_locked: assert property ( // [RQ10]
		wr && (paddr_in == `I2CM_A_CTRL)
			&& ((r.st == ST_WAIT) || (r.st == ST_HOLD))
			|=> !r.rreq)
		else $error("control write accepted during start");

	chk_rs_scl_release: assert property ( // [RQ11]
		(r.st == RS_REL) && to && r.sda_s |=> (r.st == RS_RISE)
			&& !r.scl_oe && !r.sda_oe)
		else $error("repeated start did not release scl");

	chk_rs_sda_phase: assert property ( // [RQ12]
		s_rs_high_done ##1 s_sda_low_rollover |-> r.sseen)
		else $error("repeated start sda phase wrong");

	chk_wr_starts_tx: assert property ( // [RQ18]
		wr && (paddr_in == `I2CM_A_TXBUF) && !busy
			|=> r.bf && (r.st == TX_LOW) && r.scl_oe)
		else $error("buffer write did not start byte");

	chk_eighth_fall: assert property ( // [RQ20]
		(r.st == TX_HIGH) && to && (r.bitn == `I2CM_LAST_DATA)
			&& !col |=> !r.bf && (r.st == TX_LOW)
			&& (r.bitn == `I2CM_ACK_BIT) && r.scl_oe)
		else $error("eighth fall handling wrong");

	chk_ack_sampled: assert property ( // [RQ21]
		(r.st == TX_HIGH) && to && (r.bitn == `I2CM_ACK_BIT)
			|=> (r.ackst == $past(r.sda_s)) && r.evt
			&& r.scl_oe && (r.st == ST_IDLE))
		else $error("acknowledge not sampled");

	chk_collision_release: assert property ( // [RQ23]
		col |=> r.bcol && !r.bf && !r.scl_oe && !r.sda_oe)
		else $error("collision did not release lines");

	chk_ack_slot_release: assert property ( // [RQ20]
		(r.st == TX_LOW) && (r.bitn == `I2CM_ACK_BIT) && !r.scl_s
			|=> !r.sda_oe)
		else $error("sda not released for acknowledge");

	chk_start_hold_width: assert property ( // [RQ24]
		$rose(r.st == ST_HOLD) |-> (r.cnt == ($past(r.fullw)
			? $past(r.reload) : $past(low7))) && !r.pre)
		else $error("start hold reload width wrong");

endmodule : i2cm_timing

// ---- i2cm_slave_model.sv ----
// behavioural i2c slave: captures bytes, acknowledges, stretches, collides
`timescale 1ns/10ps
module i2cm_slave_model
(
	input  wire logic       clk_in,      // core clock
	input  wire logic       scl_in,      // resolved scl
	input  wire logic       sda_in,      // resolved sda
	input  wire logic       ack_in,      // acknowledge bytes
	input  wire logic       stretch_in,  // hold scl low after falls
	input  wire logic       collide_in,  // pull sda low
	output logic            scl_oe_out,  // pulls scl low
	output logic            sda_oe_out,  // pulls sda low
	output logic [7:0]      byte_out,    // last shifted byte
	output int              min_high_out // shortest scl high time
);
	logic [3:0] nbit = 4'h0;
	logic       ack_drv = 1'b0;
	logic       scl_d = 1'b1;
	int         st_cnt = 0;
	int         hi_cnt = 0;

	initial byte_out = 8'h00;
	initial min_high_out = 1000;
	// start resets bit count
	always @(negedge sda_in)
		if (scl_in)
			nbit <= 4'h0;
	always @(posedge scl_in)
	begin
		if (nbit < 4'h8)
			byte_out <= {byte_out[6:0], sda_in};
		nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
	end
	// acknowledge driven from 8th fall to 9th fall
	always @(negedge scl_in)
		ack_drv <= (nbit == 4'h8) && ack_in;
	always @(posedge clk_in)
	begin
		scl_d <= scl_in;
		if (scl_d && !scl_in && stretch_in)
			st_cnt <= 10;
		else if (st_cnt > 0)
			st_cnt <= st_cnt - 1;
		if (scl_in)
			hi_cnt <= hi_cnt + 1;
		else
		begin
			if (scl_d && hi_cnt > 0 && hi_cnt < min_high_out)
				min_high_out <= hi_cnt;
			hi_cnt <= 0;
		end
	end
	assign scl_oe_out = (st_cnt > 0);
	assign sda_oe_out = ack_drv | collide_in;
endmodule : i2cm_slave_model

// ---- i2cm_timing_tb_top.sv ----
// self-checking bench for the i2c master timing block
`timescale 1ns/10ps
`include "i2cm_defines.svh"
module i2cm_timing_tb_top;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_oe, sda_oe, s_scl_oe, s_sda_oe;
	logic        ack = 1'b1;
	logic        stretch = 1'b0;
	logic        collide = 1'b0;
	logic [7:0]  got_byte;
	int          min_high;
	wire logic   scl = ~(scl_oe | s_scl_oe);
	wire logic   sda = ~(sda_oe | s_sda_oe);
	int          n_mismatch = 0;
	int          checks_done = 0;
	logic [31:0] rd;
	logic        er;

	always #10 sys_clk_in = ~sys_clk_in;

	i2cm_timing u_i2cm_timing (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .scl_in(scl), .scl_out_out(),
		.scl_oe_out(scl_oe), .sda_in(sda), .sda_out_out(),
		.sda_oe_out(sda_oe));
	i2cm_slave_model u_i2cm_slave_model (
		.clk_in(sys_clk_in), .scl_in(scl), .sda_in(sda), .ack_in(ack),
		.stretch_in(stretch), .collide_in(collide), .scl_oe_out(s_scl_oe),
		.sda_oe_out(s_sda_oe), .byte_out(got_byte),
		.min_high_out(min_high));

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		// wait until pready is seen high; the watchdog ends it if pready never rises
		do
		begin
			@(posedge sys_clk_in);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// poll status until a flag bit sets
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do
		begin
			xfer(1'b0, `I2CM_A_STAT, 32'h0);
			n++;
		end
		while (rd[b] !== 1'b1 && n < 400);
		check(32'(rd[b]), 32'h1);
	endtask : wait_flag

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	initial
	begin
		repeat (60000) @(posedge sys_clk_in);
		n_mismatch++;
		stop_test;
	end

	initial
	begin
		repeat (16) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		xfer(1'b0, `I2CM_A_RELOAD, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, `I2CM_A_CFG, 32'h0);
		check(rd, 32'h1);
		xfer(1'b0, 8'h20, 32'h0);
		check({rd[30:0], er}, 32'h1);
		$display("test reset done");
		xfer(1'b1, `I2CM_A_RELOAD, 32'h1);
		xfer(1'b1, `I2CM_A_CTRL, 32'h1);
		xfer(1'b1, `I2CM_A_TXBUF, 32'h3C);
		xfer(1'b1, `I2CM_A_CTRL, 32'h2);
		wait_flag(`I2CM_S_EVT);
		check(rd, 32'h0E);
		xfer(1'b0, `I2CM_A_CTRL, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, `I2CM_A_TXBUF, 32'h0);
		check(rd, 32'h0);
		check({30'h0, scl, sda}, 32'h2);
		$display("test start done");
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		xfer(1'b1, `I2CM_A_TXBUF, 32'hA5);
		xfer(1'b0, `I2CM_A_STAT, 32'h0);
		check(rd, 32'h21);
		xfer(1'b1, `I2CM_A_TXBUF, 32'hFF);
		wait_flag(`I2CM_S_EVT);
		check(rd, 32'h0A);
		check(32'(got_byte), 32'hA5);
		xfer(1'b0, `I2CM_A_CTRL, 32'h0);
		check(rd, 32'h0);
		repeat (40) @(posedge sys_clk_in);
		check(32'(scl), 32'h0);
		check(32'(min_high >= 4), 32'h1);
		$display("test byte ack done");
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		ack <= 1'b0;
		stretch <= 1'b1;
		xfer(1'b1, `I2CM_A_TXBUF, 32'h5A);
		xfer(1'b1, `I2CM_A_CTRL, 32'h2);
		wait_flag(`I2CM_S_EVT);
		check(rd, 32'h08);
		check(32'(got_byte), 32'h5A);
		xfer(1'b0, `I2CM_A_CTRL, 32'h0);
		check(rd, 32'h40);
		check(32'(min_high >= 4), 32'h1);
		stretch <= 1'b0;
		$display("test byte nack stretch done");
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		xfer(1'b1, `I2CM_A_CTRL, 32'h2);
		wait_flag(`I2CM_S_EVT);
		check(rd, 32'h0C);
		xfer(1'b0, `I2CM_A_CTRL, 32'h0);
		check(rd, 32'h40);
		check({30'h0, scl, sda}, 32'h2);
		$display("test repeated start done");
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		collide <= 1'b1;
		xfer(1'b1, `I2CM_A_TXBUF, 32'hFF);
		wait_flag(`I2CM_S_BCOL);
		check(rd & 32'h31, 32'h10);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		$display("test data collision done");
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		xfer(1'b1, `I2CM_A_CTRL, 32'h1);
		wait_flag(`I2CM_S_BCOL);
		check(rd & 32'h24, 32'h0);
		xfer(1'b0, `I2CM_A_CTRL, 32'h0);
		check(rd & 32'h3, 32'h0);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		collide <= 1'b0;
		$display("test start collision done");
		// line pulled low while the start waits its first rollover
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		xfer(1'b1, `I2CM_A_CTRL, 32'h1);
		collide <= 1'b1;
		wait_flag(`I2CM_S_BCOL);
		check(rd & 32'h2C, 32'h0);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		collide <= 1'b0;
		$display("test start wait collision done");
		// bit 7 of the reload makes the two hold widths differ
		xfer(1'b1, `I2CM_A_STAT, 32'h1E);
		xfer(1'b1, `I2CM_A_RELOAD, 32'h81);
		xfer(1'b1, `I2CM_A_CFG, 32'h0);
		xfer(1'b0, `I2CM_A_CFG, 32'h0);
		check(rd, 32'h0);
		xfer(1'b1, `I2CM_A_CTRL, 32'h1);
		repeat (20) @(posedge sys_clk_in);
		xfer(1'b0, `I2CM_A_STAT, 32'h0);
		check(rd, 32'h0C);
		check({30'h0, scl, sda}, 32'h2);
		$display("test short start hold done");
		stop_test;
	end
endmodule : i2cm_timing_tb_top
